// ==== inc/motor_defines.svh ====
// register offsets, field positions, reset values and timing counts of the tape motor line block
`ifndef MOTOR_DEFINES_SVH
`define MOTOR_DEFINES_SVH

// register map, word index on the plain register port
`define ADDR_CTRL      4'h0
`define ADDR_STATUS    4'h1
`define ADDR_IRQ_STAT  4'h2
`define ADDR_IRQ_CLR   4'h3
`define ADDR_IRQ_EN    4'h4

// control fields
`define CTRL_STALL_EN  0
`define CTRL_BRAKE_EN  1
`define CTRL_RESET     16'h0003

// status fields
`define STAT_MODE_LSB  0
`define STAT_MODE_MSB  2
`define STAT_BRAKE     3
`define STAT_STALL_N   4
`define STAT_TAPE_N    5

// interrupt fields
`define IRQ_STALL      0
`define IRQ_TAPE_END   1
`define IRQ_BRAKE_DONE 2
`define IRQ_ILLEGAL    3
`define IRQ_BITS       4
`define IRQ_EN_RESET   4'h0

// timing
`define CLOCK_MHZ      20
`define STALL_DELAY_NS 100000
`define BRAKE_TIME_NS  40000000
`define STALL_CYCLES   ((`STALL_DELAY_NS * `CLOCK_MHZ) / 1000)
`define BRAKE_CYCLES   ((`BRAKE_TIME_NS * `CLOCK_MHZ) / 1000)
`define TIMER_WIDTH    20

`endif

// ==== inc/motor_pkg.sv ====
// types of the tape motor line block
package motor_pkg;

  typedef enum logic [2:0] {
    MODE_INACTIVE,
    MODE_RW,
    MODE_FFWD,
    MODE_FREV,
    MODE_FBRAKE,
    MODE_RBRAKE,
    MODE_ILLEGAL
  } mode_e;

endpackage

// ==== inc/timer_if.sv ====
// start, clear and status signals between the block and one interval timer
`timescale 1ns/10ps
interface timer_if;
  logic start;
  logic clear;
  logic busy;
  logic done;

  modport owner (output start, output clear, input busy, input done);
  modport timer (input start, input clear, output busy, output done);
endinterface

// ==== core/interval_timer.sv ====
// non-retriggerable interval timer with one-cycle done pulse
`timescale 1ns/10ps
module interval_timer #(
  parameter int unsigned            WIDTH  = 20,
  parameter logic [WIDTH-1:0]       CYCLES = 20'h00010
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic ce,
  // control
  timer_if.timer    tif
);

  logic [WIDTH-1:0] cnt_q;

  assign tif.busy = (cnt_q != '0);
  assign tif.done = ce & ~tif.clear & (cnt_q == WIDTH'(1));

  always_ff @(posedge clock) begin
    if (!rstn) begin
      cnt_q <= '0;
    end else if (ce) begin
      if (tif.clear) begin
        cnt_q <= '0;
      end else if (tif.busy) begin
        cnt_q <= cnt_q - WIDTH'(1);
      end else if (tif.start) begin
        cnt_q <= CYCLES;
      end
    end
  end

  AST_DONE_AFTER_LOAD: assert property (@(posedge clock) disable iff (!rstn)
    tif.done |-> tif.busy ##1 !tif.busy)
    else $error("timer done without running count");

endmodule

// ==== core/tape_motor_line_controller.sv ====
// motor-side logic of the tape transport: brake one-shot, stall delay, tape-end sense, registers
//
// Behaviour
// [R1] read/write: forward-run low, others high
// [R2] fast forward: as read/write, feedback-defeat low
// [R3] fast reverse: reverse-select, reverse-source low
// [R4] forward brake: defeat, source, brake-pulse low
// [R5] reverse brake: defeat and brake-pulse low
// [R6] inactive: all five lines high
// [R7] brake falling edge fires timed ground one-shot
// [R8] stall low only after sustained overcurrent delay
// [R9] controller stops motors on stall, flags it
// [R10] tape-end high while tape blocks light
// [R11] tape-end low when light passes hole/leader
// [R12] lines high after reset, tabulated only
`timescale 1ns/10ps
`include "motor_defines.svh"
module tape_motor_line_controller #(
  parameter int unsigned BRAKE_CYCLES = `BRAKE_CYCLES
) (
  // clock, reset, enable
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        ce,
  // register port
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [15:0] rdata,
  // motor control lines from the controller
  input  wire logic        feedback_defeat_n,
  input  wire logic        reverse_source_n,
  input  wire logic        forward_run_n,
  input  wire logic        brake_pulse_n,
  input  wire logic        reverse_select_n,
  // analog sense inputs
  input  wire logic        overcurrent,
  input  wire logic        tape_light,
  // indications and drive
  output logic             motor_overcurrent_n,
  output logic             tape_end_n,
  output logic             brake_ground,
  output logic             irq
);

  localparam logic [`TIMER_WIDTH-1:0] STALL_LOAD = `TIMER_WIDTH'(`STALL_CYCLES);
  localparam logic [`TIMER_WIDTH-1:0] BRAKE_LOAD = `TIMER_WIDTH'(BRAKE_CYCLES);

  // line decode to transport mode
  function automatic motor_pkg::mode_e decode_lines(input logic [4:0] l);
    motor_pkg::mode_e m;
    m = motor_pkg::MODE_ILLEGAL;
    case (l)
      5'h1F:   m = motor_pkg::MODE_INACTIVE; // [R6] [R12]
      5'h1B:   m = motor_pkg::MODE_RW;       // [R1]
      5'h0B:   m = motor_pkg::MODE_FFWD;     // [R2]
      5'h16:   m = motor_pkg::MODE_FREV;     // [R3]
      5'h05:   m = motor_pkg::MODE_FBRAKE;   // [R4]
      5'h0D:   m = motor_pkg::MODE_RBRAKE;   // [R5]
      default: m = motor_pkg::MODE_ILLEGAL;
    endcase
    return m;
  endfunction

  motor_pkg::mode_e      mode_d;
  motor_pkg::mode_e      mode_q;
  logic [15:0]           ctrl_q;
  logic [`IRQ_BITS-1:0]  irq_stat_q;
  logic [`IRQ_BITS-1:0]  irq_stat_d;
  logic [`IRQ_BITS-1:0]  irq_en_q;
  logic [`IRQ_BITS-1:0]  irq_clr;
  logic [`IRQ_BITS-1:0]  events;
  logic                  brake_prev_q;
  logic                  brake_fall;
  logic                  stall_n_q;
  logic                  tape_end_n_q;
  logic                  stall_en;

  timer_if brake_tif();
  timer_if stall_tif();

  assign mode_d = decode_lines({feedback_defeat_n, reverse_source_n, forward_run_n,
                                brake_pulse_n, reverse_select_n});
  assign stall_en = ctrl_q[`CTRL_STALL_EN];

  // brake one-shot
  assign brake_fall = brake_prev_q & ~brake_pulse_n;
  assign brake_tif.start = brake_fall & ctrl_q[`CTRL_BRAKE_EN]; // [R7]
  assign brake_tif.clear = 1'b0;
  assign brake_ground = brake_tif.busy; // [R7]

  interval_timer #(
    .WIDTH  (`TIMER_WIDTH),
    .CYCLES (BRAKE_LOAD)
  ) brake_timer (
    .clock (clock),
    .rstn  (rstn),
    .ce    (ce),
    .tif   (brake_tif)
  );

  // stall delay: restarts whenever current falls back
  assign stall_tif.start = overcurrent & stall_en & stall_n_q; // [R8]
  assign stall_tif.clear = ~overcurrent | ~stall_en; // [R8]

  interval_timer #(
    .WIDTH  (`TIMER_WIDTH),
    .CYCLES (STALL_LOAD)
  ) stall_timer (
    .clock (clock),
    .rstn  (rstn),
    .ce    (ce),
    .tif   (stall_tif)
  );

  always_ff @(posedge clock) begin
    if (!rstn) begin
      brake_prev_q <= 1'b1;
    end else if (ce) begin
      brake_prev_q <= brake_pulse_n;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      stall_n_q <= 1'b1;
    end else if (ce) begin
      if (!overcurrent || !stall_en) begin
        stall_n_q <= 1'b1; // [R8]
      end else if (stall_tif.done) begin
        stall_n_q <= 1'b0; // [R8]
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      tape_end_n_q <= 1'b1;
    end else if (ce) begin
      tape_end_n_q <= ~tape_light; // [R10] [R11]
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      mode_q <= motor_pkg::MODE_INACTIVE;
    end else if (ce) begin
      mode_q <= mode_d;
    end
  end

  assign motor_overcurrent_n = stall_n_q;
  assign tape_end_n = tape_end_n_q;

  // interrupt events, set wins over clear
  always_comb begin
    events = '0;
    events[`IRQ_STALL] = stall_tif.done & overcurrent & stall_en;
    events[`IRQ_TAPE_END] = tape_light & tape_end_n_q;
    events[`IRQ_BRAKE_DONE] = brake_tif.done;
    events[`IRQ_ILLEGAL] = (mode_d == motor_pkg::MODE_ILLEGAL) && (mode_q != motor_pkg::MODE_ILLEGAL);
    irq_clr = '0;
    if (wr_en && (addr == `ADDR_IRQ_CLR)) begin
      irq_clr = wdata[`IRQ_BITS-1:0];
    end
    irq_stat_d = (irq_stat_q & ~irq_clr) | events;
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      irq_stat_q <= '0;
    end else if (ce) begin
      irq_stat_q <= irq_stat_d;
    end
  end

  assign irq = |(irq_stat_q & irq_en_q);

  // register writes
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ctrl_q <= `CTRL_RESET;
      irq_en_q <= `IRQ_EN_RESET;
    end else if (ce && wr_en) begin
      if (addr == `ADDR_CTRL) begin
        ctrl_q <= {14'h0000, wdata[1:0]};
      end else if (addr == `ADDR_IRQ_EN) begin
        irq_en_q <= wdata[`IRQ_BITS-1:0];
      end
    end
  end

  // register reads, data in the following cycle
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rdata <= 16'h0000;
    end else if (ce) begin
      rdata <= 16'h0000;
      if (rd_en) begin
        if (addr == `ADDR_CTRL) begin
          rdata <= ctrl_q;
        end else if (addr == `ADDR_STATUS) begin
          rdata <= {10'h000, tape_end_n_q, stall_n_q, brake_tif.busy, mode_q};
        end else if (addr == `ADDR_IRQ_STAT) begin
          rdata <= {12'h000, irq_stat_q};
        end else if (addr == `ADDR_IRQ_EN) begin
          rdata <= {12'h000, irq_en_q};
        end
      end
    end
  end

  // helper: length of the current overcurrent run
  logic [`TIMER_WIDTH-1:0] oc_run_q;
  always_ff @(posedge clock) begin
    if (!rstn) begin
      oc_run_q <= '0;
    end else if (ce) begin
      if (!overcurrent) begin
        oc_run_q <= '0;
      end else if (oc_run_q != '1) begin
        oc_run_q <= oc_run_q + `TIMER_WIDTH'(1);
      end
    end
  end

  AST_BRAKE_FIRE: assert property (@(posedge clock) disable iff (!rstn) // [R7]
    ce && brake_fall && ctrl_q[`CTRL_BRAKE_EN] && !brake_ground |=> brake_ground)
    else $error("brake falling edge did not fire one-shot");

  AST_BRAKE_HOLD: assert property (@(posedge clock) disable iff (!rstn) // [R7]
    $rose(brake_ground) |-> brake_ground [*8])
    else $error("brake ground ended too early");

  AST_STALL_DELAY: assert property (@(posedge clock) disable iff (!rstn) // [R8]
    $fell(motor_overcurrent_n) |-> (oc_run_q >= STALL_LOAD))
    else $error("stall asserted before delay expired");

  AST_STALL_RELEASE: assert property (@(posedge clock) disable iff (!rstn) // [R8]
    ce && !overcurrent |=> motor_overcurrent_n)
    else $error("stall held without overcurrent");

  AST_TAPE_BLOCKED: assert property (@(posedge clock) disable iff (!rstn) // [R10]
    ce && !tape_light |=> tape_end_n)
    else $error("tape end low while tape blocks light");

  AST_TAPE_HOLE: assert property (@(posedge clock) disable iff (!rstn) // [R11]
    ce && tape_light |=> !tape_end_n)
    else $error("tape end not signalled on light");

  AST_TAPE_FLAG: assert property (@(posedge clock) disable iff (!rstn) // [R11]
    ce && tape_light && tape_end_n |=> irq_stat_q[`IRQ_TAPE_END])
    else $error("tape end event not flagged");

  COV_BRAKE: cover property (@(posedge clock) disable iff (!rstn) $rose(brake_ground));
  COV_STALL: cover property (@(posedge clock) disable iff (!rstn) $fell(motor_overcurrent_n));
  COV_TAPE: cover property (@(posedge clock) disable iff (!rstn) $fell(tape_end_n));
  COV_IRQ: cover property (@(posedge clock) disable iff (!rstn) $rose(irq));

endmodule

// ==== verification/motor_controller_model.sv ====
// controller model driving the five motor lines from a commanded mode
`timescale 1ns/10ps
module motor_controller_model (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rstn,
  // command and stall sense
  input  wire logic [2:0] mode,
  input  wire logic       stall_n,
  // lines: defeat, source, run, brake, select
  output logic      [4:0] lines_n
);
  always_ff @(posedge clock) begin
    if (!rstn || !stall_n) begin
      lines_n <= 5'h1F;
    end else begin
      case (mode)
        3'h1: lines_n <= 5'h1B;
        3'h2: lines_n <= 5'h0B;
        3'h3: lines_n <= 5'h16;
        3'h4: lines_n <= 5'h05;
        3'h5: lines_n <= 5'h0D;
        3'h6: lines_n <= 5'h00;
        default: lines_n <= 5'h1F;
      endcase
    end
  end
endmodule

// ==== verification/tape_motor_line_controller_tb_top.sv ====
// self-checking bench of the tape motor line block
`timescale 1ns/10ps
module tape_motor_line_controller_tb_top;
  logic clock, rstn, ce, wr_en, rd_en, overcurrent, tape_light;
  logic [3:0]  addr;
  logic [15:0] wdata, rdata, d;
  logic [4:0]  ln;
  logic [2:0]  mode;
  logic motor_overcurrent_n, tape_end_n, brake_ground, irq;
  int errors, tests_run, cycles, n;
  integer seed;

  tape_motor_line_controller #(.BRAKE_CYCLES(20)) dut (
    .clock(clock), .rstn(rstn), .ce(ce), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .feedback_defeat_n(ln[4]), .reverse_source_n(ln[3]), .forward_run_n(ln[2]),
    .brake_pulse_n(ln[1]), .reverse_select_n(ln[0]), .overcurrent(overcurrent), .tape_light(tape_light),
    .motor_overcurrent_n(motor_overcurrent_n), .tape_end_n(tape_end_n), .brake_ground(brake_ground),
    .irq(irq));
  motor_controller_model ctl (.clock(clock), .rstn(rstn), .mode(mode), .stall_n(motor_overcurrent_n),
    .lines_n(ln));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  function automatic logic exp_tape(input logic light);
    return ~light;
  endfunction

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clock);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic report_and_stop;
    if (errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      report_and_stop;
    end
  end

  initial begin
    seed = 32'hB88B231A;
    {rstn, wr_en, rd_en, overcurrent, tape_light, addr, wdata, mode} = '0;
    ce = 1'b1;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    rd(4'h0); chk("ctrl", 16'h0003, d);
    rd(4'h1); chk("status", 16'h0030, d);
    rd(4'hF); chk("unmapped", 16'h0000, d);
    mode <= 3'h4;
    n = 0;
    while (brake_ground !== 1'b1 && n < 10) begin
      @(negedge clock);
      n++;
    end
    n = 0;
    while (brake_ground === 1'b1 && n < 100) begin
      n++;
      if (n == 5) mode <= 3'h0;
      if (n == 8) mode <= 3'h5;
      @(negedge clock);
    end
    chk("brake_len", 16'd20, 16'(n));
    rd(4'h2); chk("brake_done", 16'h0004, d & 16'h0004);
    for (int m = 0; m < 7; m++) begin
      mode <= 3'(m);
      repeat (4) @(posedge clock);
      rd(4'h1); chk("mode", 16'(m), d & 16'h0007);
    end
    rd(4'h2); chk("illegal", 16'h0008, d & 16'h0008);
    mode <= 3'h1;
    repeat (30) begin
      @(posedge clock);
      tape_light <= 1'($random(seed));
      @(posedge clock);
      @(negedge clock);
      chk("tape_end_n", 16'(exp_tape(tape_light)), 16'(tape_end_n));
    end
    tape_light <= 1'b0;
    wr(4'h3, 16'h000F);
    rd(4'h2); chk("irq_clr", 16'h0000, d);
    wr(4'h4, 16'h0002);
    rd(4'h4); chk("irq_en", 16'h0002, d);
    tape_light <= 1'b1;
    repeat (3) @(posedge clock);
    #1 chk("irq", 16'h0001, 16'(irq));
    wr(4'h4, 16'h0000);
    #1 chk("irq_mask", 16'h0000, 16'(irq));
    ce <= 1'b0;
    tape_light <= 1'b0;
    repeat (2) @(posedge clock);
    #1 chk("ce_hold", 16'h0000, 16'(tape_end_n));
    ce <= 1'b1;
    overcurrent <= 1'b1;
    repeat (100 + ($random(seed) & 16'h03FF)) @(posedge clock);
    #1 chk("peak", 16'h0001, 16'(motor_overcurrent_n));
    overcurrent <= 1'b0;
    repeat (3) @(posedge clock);
    overcurrent <= 1'b1;
    n = 0;
    while (motor_overcurrent_n !== 1'b0 && n < 3000) begin
      @(negedge clock);
      n++;
    end
    chk("stall_delay", 16'h0001, 16'(n >= 1999 && n <= 2003));
    repeat (4) @(posedge clock);
    rd(4'h1); chk("stall_stop", 16'h0000, d & 16'h0017);
    rd(4'h2); chk("stall_flag", 16'h0001, d & 16'h0001);
    overcurrent <= 1'b0;
    repeat (2) @(posedge clock);
    #1 chk("stall_end", 16'h0001, 16'(motor_overcurrent_n));
    wr(4'h0, 16'h0001);
    rd(4'h0); chk("ctrl_wr", 16'h0001, d);
    mode <= 3'h4;
    repeat (4) @(posedge clock);
    #1 chk("brake_off", 16'h0000, 16'(brake_ground));
    report_and_stop;
  end
endmodule
